// [core/agclf_pkg.sv]
`default_nettype none
package agclf_pkg;
	// Control word addresses on the microprocessor write port
	localparam logic [7:0] AGCLF_CW_LOOP_PARAM = 8'h08;
	localparam logic [7:0] AGCLF_CW_GAIN_LIMITS = 8'h09;
	localparam logic [7:0] AGCLF_CW_BACKEND_RESET = 8'h19;
	localparam logic [7:0] AGCLF_CW_EXT_CONFIG = 8'h1b;

	// Loop parameter word fields
	localparam int AGCLF_SET0_LSB = 0;
	localparam int AGCLF_SET1_LSB = 8;
	localparam int AGCLF_MAGNITUDE_TARGET_LSB = 16;
	localparam int AGCLF_MAGNITUDE_TARGET_W = 13;

	// Limit word fields
	localparam int AGCLF_LIM_LO_LSB = 0;
	localparam int AGCLF_LIM_HI_LSB = 16;
	localparam int AGCLF_LIM_W = 12;

	// Extended configuration bits
	localparam int AGCLF_RETAIN_BIT = 15;
	localparam int AGCLF_MEDIAN_BIT = 16;

	// Datapath geometry
	localparam int AGCLF_ACC_W = 32;
	localparam int AGCLF_ERR_W = 14;
	localparam int AGCLF_TERM_W = 34;
	localparam int AGCLF_ALIGN = 11;
	localparam int AGCLF_LIM_PAD = 20;
	localparam int AGCLF_GAIN_W = 20;
	localparam logic [3:0] AGCLF_EXP_MAX = 4'hf;

	// Fixed median-mode errors, 13-bit two's complement
	localparam logic [12:0] AGCLF_STEP_POS = 13'h0400;
	localparam logic [12:0] AGCLF_STEP_NEG = 13'h1c00;

	// Values after reset
	localparam logic [31:0] AGCLF_LOOP_PARAM_RST = 32'h0000_0000;
	localparam logic [31:0] AGCLF_GAIN_LIMITS_RST = 32'h0000_0000;
	localparam logic [31:0] AGCLF_EXT_CONFIG_RST = 32'h0000_0000;
	localparam logic [31:0] AGCLF_ACC_RST = 32'h0000_0000;

	// One loop gain setting
	typedef struct packed {
		logic [3:0] loop_gain_exponent;
		logic [3:0] loop_gain_mantissa;
	} agclf_loop_gain_t;

	// One gain limit
	typedef struct packed {
		logic [3:0] exponent;
		logic [7:0] mantissa;
	} agclf_limit_t;

	// Control word write strobe with address and data
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [31:0] data;
	} agclf_cw_write_t;

	typedef enum logic [0:0] {
		AGCLF_MODE_MEAN = 1'b0,
		AGCLF_MODE_MEDIAN = 1'b1
	} agclf_mode_t;
endpackage
`default_nettype wire

// [core/agclf_sync.sv]
`default_nettype none
// Two-flop synchroniser for pin levels
module agclf_sync #(
	parameter int W = 1
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			meta_reg <= '0;
			o_sync <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// [core/agclf_err_scaler.sv]
`default_nettype none
// Scales the gain error by mantissa/16 and by 2^-(15-E), aligned to accumulator
module agclf_err_scaler (
	input wire logic signed [agclf_pkg::AGCLF_ERR_W-1:0] i_err,
	input wire agclf_pkg::agclf_loop_gain_t i_gain,
	output logic signed [agclf_pkg::AGCLF_TERM_W-1:0] o_term
);
	logic signed [18:0] prod;
	logic signed [agclf_pkg::AGCLF_TERM_W-1:0] ext;
	logic signed [agclf_pkg::AGCLF_TERM_W-1:0] aligned;
	logic [3:0] shamt;

	// Mantissa code over sixteen, exponent as right shift of 15-E
	// Operands widened first so the product never shrinks to the error width
	assign prod = 19'(i_err) * 19'($signed({1'b0, i_gain.loop_gain_mantissa}));
	assign ext = agclf_pkg::AGCLF_TERM_W'(prod);
	assign aligned = ext <<< agclf_pkg::AGCLF_ALIGN;
	assign shamt = agclf_pkg::AGCLF_EXP_MAX - i_gain.loop_gain_exponent;
	assign o_term = aligned >>> shamt;
endmodule
`default_nettype wire

// [core/agclf_loop_filter.sv]
// Behaviour
// - two mantissa/exponent loop gains in bits 0-15
// - select pin low picks set 0, high set 1
// - accumulator clamped between programmed gain limits
// - limit is 8-bit mantissa, 4-bit exponent
// - upper limit bits 16-27, lower 0-11
// - exponent top four bits, mantissa low eight
// - loop mantissa scales error by code/16
// - loop exponent attenuates by 2^(15-E)
// - retain bit spares accumulator from back-end reset
// - bit 16 selects median, else mean mode
// - mean mode adds scaled signed error
// - median mode uses fixed step by error sign
// - median step scaled by same loop gain
// - one accumulator update per output sample
// - error is threshold minus magnitude
// - gain captured only when multiplier loads data
`default_nettype none
module agclf_loop_filter (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_cw_wr,
	input wire logic [7:0] i_cw_addr,
	input wire logic [31:0] i_cw_data,
	input wire logic i_loop_gain_select_pin,
	input wire logic i_second_sync_input,
	input wire logic i_sample_valid,
	input wire logic [agclf_pkg::AGCLF_MAGNITUDE_TARGET_W-1:0] i_magnitude,
	input wire logic i_mult_load,
	output logic [agclf_pkg::AGCLF_GAIN_W-1:0] o_gain,
	output logic o_active_gain_set,
	output logic o_median_mode
);
	localparam int ACC_W = agclf_pkg::AGCLF_ACC_W;
	localparam int TERM_W = agclf_pkg::AGCLF_TERM_W;

	agclf_pkg::agclf_cw_write_t cw;
	logic [31:0] loop_params_reg;
	logic [31:0] gain_limits_reg;
	logic [31:0] ext_config_reg;
	logic [ACC_W-1:0] acc_reg;
	logic [ACC_W-1:0] acc_next;
	logic sync_d_reg;
	logic [1:0] pins_sync;
	logic sel_sync;
	logic sync_lvl;

	// Bundle the control word write
	assign cw = '{wr: i_cw_wr, addr: i_cw_addr, data: i_cw_data};

	function automatic logic cw_hit(input agclf_pkg::agclf_cw_write_t w,
		input logic [7:0] a);
		cw_hit = w.wr && (w.addr == a);
	endfunction

	wire wr_loop = cw_hit(cw, agclf_pkg::AGCLF_CW_LOOP_PARAM);
	wire wr_limits = cw_hit(cw, agclf_pkg::AGCLF_CW_GAIN_LIMITS);
	wire wr_ext = cw_hit(cw, agclf_pkg::AGCLF_CW_EXT_CONFIG);
	wire wr_backend = cw_hit(cw, agclf_pkg::AGCLF_CW_BACKEND_RESET);

	// Control word storage
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			loop_params_reg <= agclf_pkg::AGCLF_LOOP_PARAM_RST;
			gain_limits_reg <= agclf_pkg::AGCLF_GAIN_LIMITS_RST;
			ext_config_reg <= agclf_pkg::AGCLF_EXT_CONFIG_RST;
		end else begin
			if (wr_loop) begin
				loop_params_reg <= cw.data;
			end
			if (wr_limits) begin
				gain_limits_reg <= cw.data;
			end
			if (wr_ext) begin
				ext_config_reg <= cw.data;
			end
		end
	end

	// Pins come from outside the clock domain
	agclf_sync #(.W(2)) u_pin_sync (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_async({i_second_sync_input, i_loop_gain_select_pin}),
		.o_sync(pins_sync)
	);
	assign sel_sync = pins_sync[0];
	assign sync_lvl = pins_sync[1];

	// Rising edge of the synchronised sync input
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			sync_d_reg <= 1'b0;
		end else begin
			sync_d_reg <= sync_lvl;
		end
	end
	wire sync_rise = sync_lvl && !sync_d_reg;

	// Field decode
	agclf_pkg::agclf_loop_gain_t gain_set0;
	agclf_pkg::agclf_loop_gain_t gain_set1;
	agclf_pkg::agclf_loop_gain_t gain_used;
	agclf_pkg::agclf_limit_t lim_hi;
	agclf_pkg::agclf_limit_t lim_lo;
	agclf_pkg::agclf_mode_t mode;
	logic [agclf_pkg::AGCLF_MAGNITUDE_TARGET_W-1:0] magnitude_target;
	logic retain;

	assign gain_set0 = loop_params_reg[agclf_pkg::AGCLF_SET0_LSB +: 8];
	assign gain_set1 = loop_params_reg[agclf_pkg::AGCLF_SET1_LSB +: 8];
	assign gain_used = sel_sync ? gain_set1 : gain_set0;
	assign magnitude_target = loop_params_reg[agclf_pkg::AGCLF_MAGNITUDE_TARGET_LSB +: agclf_pkg::AGCLF_MAGNITUDE_TARGET_W];
	// Exponent in top nibble by struct layout
	assign lim_hi = gain_limits_reg[agclf_pkg::AGCLF_LIM_HI_LSB +: agclf_pkg::AGCLF_LIM_W];
	assign lim_lo = gain_limits_reg[agclf_pkg::AGCLF_LIM_LO_LSB +: agclf_pkg::AGCLF_LIM_W];
	assign retain = ext_config_reg[agclf_pkg::AGCLF_RETAIN_BIT];
	assign mode = agclf_pkg::agclf_mode_t'(ext_config_reg[agclf_pkg::AGCLF_MEDIAN_BIT]);

	// Error detector: threshold minus magnitude, both unsigned
	logic signed [agclf_pkg::AGCLF_ERR_W-1:0] err_true;
	logic signed [agclf_pkg::AGCLF_ERR_W-1:0] err_step;
	logic signed [agclf_pkg::AGCLF_ERR_W-1:0] err_used;
	assign err_true = $signed({1'b0, magnitude_target}) - $signed({1'b0, i_magnitude});

	// Median replaces the error by a fixed step; zero counts as positive
	assign err_step = err_true[agclf_pkg::AGCLF_ERR_W-1] ?
		$signed({agclf_pkg::AGCLF_STEP_NEG[12], agclf_pkg::AGCLF_STEP_NEG}) :
		$signed({agclf_pkg::AGCLF_STEP_POS[12], agclf_pkg::AGCLF_STEP_POS});
	assign err_used = (mode == agclf_pkg::AGCLF_MODE_MEDIAN) ? err_step : err_true;

	// Both modes pass through the same scaler
	logic signed [TERM_W-1:0] term;
	agclf_err_scaler u_scaler (
		.i_err(err_used),
		.i_gain(gain_used),
		.o_term(term)
	);

	// Limits occupy the top twelve accumulator bits
	logic signed [TERM_W-1:0] sum;
	logic signed [TERM_W-1:0] hi_ext;
	logic signed [TERM_W-1:0] lo_ext;
	assign sum = $signed({2'b00, acc_reg}) + term;
	assign hi_ext = $signed({2'b00, lim_hi, {agclf_pkg::AGCLF_LIM_PAD{1'b0}}});
	assign lo_ext = $signed({2'b00, lim_lo, {agclf_pkg::AGCLF_LIM_PAD{1'b0}}});

	// Saturate rather than wrap; if limits cross, a sum below the lower limit takes it, any other sum the upper
	always_comb begin
		if (sum < lo_ext) begin
			acc_next = ACC_W'(lo_ext);
		end else if (sum > hi_ext) begin
			acc_next = ACC_W'(hi_ext);
		end else begin
			acc_next = ACC_W'(sum);
		end
	end

	// Back-end reset honours retain; the sync pin always clears
	wire acc_clear = sync_rise || (wr_backend && !retain);

	// One update per output sample; clear beats a same-cycle sample
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			acc_reg <= agclf_pkg::AGCLF_ACC_RST;
		end else if (acc_clear) begin
			acc_reg <= agclf_pkg::AGCLF_ACC_RST;
		end else if (i_sample_valid) begin
			acc_reg <= acc_next;
		end
	end

	// Gain handed to the multiplier only as it loads a new sample
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_gain <= '0;
			o_active_gain_set <= 1'b0;
			o_median_mode <= 1'b0;
		end else begin
			if (i_mult_load) begin
				o_gain <= acc_reg[ACC_W-1 -: agclf_pkg::AGCLF_GAIN_W];
			end
			o_active_gain_set <= sel_sync;
			o_median_mode <= (mode == agclf_pkg::AGCLF_MODE_MEDIAN);
		end
	end

	// Checks
	wire upd = i_sample_valid && !acc_clear;
	wire lims_ok = lo_ext <= hi_ext;
	wire median_sel = mode == agclf_pkg::AGCLF_MODE_MEDIAN;
	wire [agclf_pkg::AGCLF_GAIN_W-1:0] acc_top = acc_reg[ACC_W-1 -: agclf_pkg::AGCLF_GAIN_W];

	property p_acc_below_hi;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		upd && lims_ok && !wr_limits |=> $signed({2'b00, acc_reg}) <= $past(hi_ext);
	endproperty
	a_acc_below_hi: assert property (p_acc_below_hi) else $error("acc above hi");

	property p_acc_above_lo;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		upd && !wr_limits |=> $signed({2'b00, acc_reg}) >= $past(lo_ext);
	endproperty
	a_acc_above_lo: assert property (p_acc_above_lo) else $error("acc below lo");

	property p_clear;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_backend && !retain |=> acc_reg == agclf_pkg::AGCLF_ACC_RST;
	endproperty
	a_clear: assert property (p_clear) else $error("backend reset missed");

	property p_retain;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_backend && retain && !sync_rise && !i_sample_valid |=> $stable(acc_reg);
	endproperty
	a_retain: assert property (p_retain) else $error("retained acc lost");

	property p_hold;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		!i_sample_valid && !acc_clear |=> $stable(acc_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("acc moved without sample");

	property p_sel_path;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		i_loop_gain_select_pin [*3] |=> o_active_gain_set;
	endproperty
	a_sel_path: assert property (p_sel_path) else $error("gain set not followed");

	// Sign of the true error alone picks the step, so each sign is checked apart
	property p_median_err;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		median_sel && !err_true[agclf_pkg::AGCLF_ERR_W-1] |-> err_used == 14'sh0400;
	endproperty
	a_median_err: assert property (p_median_err) else $error("median step wrong");

	property p_median_neg;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		median_sel && err_true[agclf_pkg::AGCLF_ERR_W-1] |-> err_used == 14'sh3c00;
	endproperty
	a_median_neg: assert property (p_median_neg) else $error("median neg step wrong");

	property p_gain_capture;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		!i_mult_load |=> $stable(o_gain);
	endproperty
	a_gain_capture: assert property (p_gain_capture) else $error("gain changed early");

	property p_zero_gain;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		upd && gain_used.loop_gain_mantissa == 4'h0 && sum >= lo_ext && sum <= hi_ext
			|=> $stable(acc_reg);
	endproperty
	a_zero_gain: assert property (p_zero_gain) else $error("zero gain moved acc");

	// The sync pin clears regardless of the retain bit
	property p_sync_clear;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		sync_rise |=> acc_reg == agclf_pkg::AGCLF_ACC_RST;
	endproperty
	a_sync_clear: assert property (p_sync_clear) else $error("sync clear missed");

	property p_set0_path;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		!i_loop_gain_select_pin [*3] |=> !o_active_gain_set;
	endproperty
	a_set0_path: assert property (p_set0_path) else $error("gain set 0 not followed");

	// Overshoot lands exactly on the limit instead of wrapping
	property p_hi_pin;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		upd && lims_ok && sum > hi_ext |=> $signed({2'b00, acc_reg}) == $past(hi_ext);
	endproperty
	a_hi_pin: assert property (p_hi_pin) else $error("acc not held at hi");

	property p_lo_pin;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		upd && sum < lo_ext |=> $signed({2'b00, acc_reg}) == $past(lo_ext);
	endproperty
	a_lo_pin: assert property (p_lo_pin) else $error("acc not held at lo");

	property p_gain_load;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		i_mult_load |=> o_gain == $past(acc_top);
	endproperty
	a_gain_load: assert property (p_gain_load) else $error("gain not loaded");

	property p_mode_out;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		1'b1 |=> o_median_mode == $past(median_sel);
	endproperty
	a_mode_out: assert property (p_mode_out) else $error("mode flag stale");

	c_median_upd: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
		upd && mode == agclf_pkg::AGCLF_MODE_MEDIAN);
	c_clamp_hi: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
		upd && sum > hi_ext);
	c_retain: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_backend && retain);
	c_set1: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
		upd && sel_sync);
	c_clamp_lo: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
		upd && sum < lo_ext);
endmodule
`default_nettype wire

// [bench/agclf_gain_ctl_model.sv]
`default_nettype none
// Demodulator logic that steers the loop gain select pin
module agclf_gain_ctl_model (
	input wire logic i_sys_clk,
	input wire logic i_req,
	input wire logic i_track,
	input wire logic [3:0] i_lag,
	output logic o_loop_gain_select_pin,
	output logic o_settled
);
	timeunit 1ns;
	timeprecision 1ns;
	logic want_reg = 1'b0;
	logic pin_reg = 1'b0;
	logic [3:0] lag_reg = 4'h0;
	logic [2:0] hold_reg = 3'h0;
	assign o_loop_gain_select_pin = pin_reg;
	// A request latches the wanted set; a lag makes the answer slow
	always @(posedge i_sys_clk) begin
		if (i_req) begin
			want_reg <= i_track;
			lag_reg <= i_lag;
		end else if (lag_reg != 4'h0) begin
			lag_reg <= lag_reg - 4'h1;
		end
		// Level 0 is the fast acquisition set, level 1 the tracking set
		if (!i_req && lag_reg == 4'h0 && pin_reg != want_reg) begin
			pin_reg <= want_reg;
			hold_reg <= 3'h0;
		end else if (hold_reg != 3'h7) begin
			hold_reg <= hold_reg + 3'h1;
		end
	end
	// Settled only after the level outlasts the pin synchroniser
	assign o_settled = !i_req && lag_reg == 4'h0 && pin_reg == want_reg && hold_reg > 3'h4;
endmodule
`default_nettype wire

// [bench/agclf_loop_filter_test.sv]
`default_nettype none
module agclf_loop_filter_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic wr = 1'b0, sync2 = 1'b0, valid = 1'b0, ml = 1'b0, req = 1'b0, trk = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] data = 32'h0, lp = 32'h0, lim = 32'h0, ext = 32'h0;
	logic [12:0] mag = 13'h0;
	logic [3:0] lag = 4'h0;
	logic [19:0] shown = 20'h0;
	wire logic pin, settled, act_set, med;
	wire logic [19:0] gain;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	longint acc = 0;
	agclf_loop_filter i_agclf_loop_filter (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.i_cw_wr(wr), .i_cw_addr(addr), .i_cw_data(data), .i_loop_gain_select_pin(pin),
		.i_second_sync_input(sync2), .i_sample_valid(valid), .i_magnitude(mag),
		.i_mult_load(ml), .o_gain(gain), .o_active_gain_set(act_set), .o_median_mode(med));
	agclf_gain_ctl_model i_agclf_gain_ctl_model (.i_sys_clk(i_sys_clk), .i_req(req),
		.i_track(trk), .i_lag(lag), .o_loop_gain_select_pin(pin), .o_settled(settled));
	initial begin
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	task automatic chk_gain(input string what, input logic [19:0] ev, input logic [19:0] got);
		check_count++;
		if (got !== ev) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, ev, got);
		end
	endtask
	task automatic chk_flag(input string what, input logic ev, input logic got);
		check_count++;
		if (got !== ev) begin
			errors++;
			$display("CHECK FAILED %s expected %b seen %b", what, ev, got);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Control word write; the model keeps its own copy of the loop, limit and extended words
	task automatic cw(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		wr <= 1'b1;
		addr <= a;
		data <= d;
		@(posedge i_sys_clk);
		wr <= 1'b0;
		if (a == agclf_pkg::AGCLF_CW_LOOP_PARAM) lp = d;
		if (a == agclf_pkg::AGCLF_CW_GAIN_LIMITS) lim = d;
		if (a == agclf_pkg::AGCLF_CW_EXT_CONFIG) ext = d;
		if (a == agclf_pkg::AGCLF_CW_BACKEND_RESET && !ext[15]) acc = 0;
	endtask
	// Reference accumulator step, plain integer arithmetic
	task automatic step(input logic s);
		longint e, t, lo, hi;
		logic [7:0] g;
		e = longint'(lp[28:16]) - longint'(mag);
		if (ext[16]) e = (e < 0) ? -64'sh400 : 64'sh400;
		g = s ? lp[15:8] : lp[7:0];
		t = (e * longint'(g[3:0]) * 2048) >>> (15 - g[7:4]);
		lo = longint'({lim[11:0], 20'h0});
		hi = longint'({lim[27:16], 20'h0});
		acc = acc + t;
		if (acc < lo) acc = lo;
		else if (acc > hi) acc = hi;
	endtask
	// Optional sample, then optional multiplier load, then compare the gain
	task automatic sample(input logic [12:0] m, input logic v, input logic ld);
		@(posedge i_sys_clk);
		valid <= v;
		mag <= m;
		@(posedge i_sys_clk);
		valid <= 1'b0;
		ml <= ld;
		if (v) step(pin);
		@(posedge i_sys_clk);
		ml <= 1'b0;
		if (ld) shown = acc[31:12];
		#1;
		chk_gain("gain", shown, gain);
	endtask
	// Ask the far side for a set, promptly or slowly, and wait for it
	task automatic req_sel(input logic t, input logic [3:0] l);
		int n;
		@(posedge i_sys_clk);
		req <= 1'b1;
		trk <= t;
		lag <= l;
		@(posedge i_sys_clk);
		req <= 1'b0;
		#1;
		n = 0;
		while (settled !== 1'b1 && n < 40) begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		chk_flag("settled", 1'b1, settled);
		chk_flag("select", t, act_set);
	endtask
	// Hang guard, far above the length of the sequence
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			test_done();
		end
	end
	initial begin
		logic [31:0] d;
		void'($urandom(32'hdeb3));
		repeat (6) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		#1;
		chk_gain("gain", 20'h0, gain);
		chk_flag("median", 1'b0, med);
		$display("test reset done");
		cw(agclf_pkg::AGCLF_CW_GAIN_LIMITS, 32'h0f80_0100);
		for (int md = 0; md < 2; md++) begin
			cw(agclf_pkg::AGCLF_CW_EXT_CONFIG, {15'h0, md[0], 16'h0});
			cw(8'h0a, $urandom);
			#1;
			chk_flag("median", md[0], med);
			for (int ph = 0; ph < 6; ph++) begin
				req_sel(ph[0], 4'($urandom_range(9)));
				d = {3'h0, ph[0] ? 13'h0 : 13'h1fff, 16'hffff};
				cw(agclf_pkg::AGCLF_CW_LOOP_PARAM, (ph < 4) ? $urandom & 32'h1fff_ffff : d);
				for (int n = 0; n < 20; n++) begin
					sample((ph < 4) ? 13'($urandom) : (ph[0] ? 13'h1fff : 13'h0), 1'b1,
						n % 5 != 4);
				end
				$display("test mode %0d phase %0d done", md, ph);
			end
		end
		cw(agclf_pkg::AGCLF_CW_EXT_CONFIG, 32'h0000_8000);
		cw(agclf_pkg::AGCLF_CW_BACKEND_RESET, 32'h0);
		sample(13'h0, 1'b0, 1'b1);
		cw(agclf_pkg::AGCLF_CW_EXT_CONFIG, 32'h0);
		cw(agclf_pkg::AGCLF_CW_BACKEND_RESET, 32'h0);
		sample(13'h0, 1'b0, 1'b1);
		sample(13'h0, 1'b1, 1'b1);
		cw(agclf_pkg::AGCLF_CW_EXT_CONFIG, 32'h0000_8000);
		@(posedge i_sys_clk);
		sync2 <= 1'b1;
		repeat (5) @(posedge i_sys_clk);
		sync2 <= 1'b0;
		acc = 0;
		sample(13'h0, 1'b0, 1'b1);
		$display("test clears done");
		test_done();
	end
endmodule
`default_nettype wire
